// file: rtl/smwsp_defs.svh
// constants for the static memory wait, slow-clock and page sequencer
`ifndef SMWSP_DEFS_SVH
`define SMWSP_DEFS_SVH

`define SMWSP_CNT_W 10
`define SMWSP_CS_W 3
// slow-clock read waveform
`define SMWSP_SLOW_RD_SETUP 10'h001
`define SMWSP_SLOW_RD_PULSE 10'h001
`define SMWSP_SLOW_CS_RD_SETUP 10'h000
`define SMWSP_SLOW_CS_RD_PULSE 10'h002
`define SMWSP_SLOW_RD_CYCLE 10'h002
// slow-clock write waveform
`define SMWSP_SLOW_WR_SETUP 10'h001
`define SMWSP_SLOW_WR_PULSE 10'h001
`define SMWSP_SLOW_CS_WR_SETUP 10'h000
`define SMWSP_SLOW_CS_WR_PULSE 10'h003
`define SMWSP_SLOW_WR_CYCLE 10'h003
// external wait modes
`define SMWSP_WAIT_FROZEN 2'h2
`define SMWSP_WAIT_READY 2'h3
// page size selections
`define SMWSP_PS_4 2'h0
`define SMWSP_PS_8 2'h1
`define SMWSP_PS_16 2'h2
// data bus widths
`define SMWSP_DBW_16 2'h1
`define SMWSP_DBW_32 2'h2

`endif

// file: rtl/smwsp_pkg.sv
// types shared by the static memory wait, slow-clock and page sequencer
`include "smwsp_defs.svh"
`default_nettype none
package smwsp_pkg;

  // one waveform: lengths in master clock cycles
  typedef struct packed {
    logic [`SMWSP_CNT_W-1:0] setup;
    logic [`SMWSP_CNT_W-1:0] pulse;
    logic [`SMWSP_CNT_W-1:0] cs_setup;
    logic [`SMWSP_CNT_W-1:0] cs_pulse;
    logic [`SMWSP_CNT_W-1:0] cycle;
  } smwsp_tim_t;

  // configuration of the chip select being requested
  typedef struct packed {
    smwsp_tim_t rd;
    smwsp_tim_t wr;
    logic page_mode_enable;
    logic [1:0] page_size_sel;
    logic byte_access_type;
    logic [1:0] external_wait_mode;
    logic [1:0] data_bus_width;
  } smwsp_cfg_t;

  typedef enum logic [3:0] {
    SMWSP_IDLE = 4'h1,
    SMWSP_RELOAD = 4'h2,
    SMWSP_BREAK = 4'h4,
    SMWSP_RUN = 4'h8
  } smwsp_state_t;

endpackage
`default_nettype wire

// file: rtl/smwsp_seq.sv
// access sequencer: external wait, slow-clock waveforms, page-mode reads
//
// Behaviour
// - wait input: two sync flops, one decision
// - slow clock overrides every chip select waveform
// - slow reads: 1,1,0,2, cycle 2
// - slow writes: 1,1,0,3, cycle 3
// - running transfer finishes with its own set
// - one reload wait on mode change
// - page bursts only when page mode enabled
// - pages aligned to 4/8/16/32 bytes
// - drop low address bits for wide memories
// - page reads: strobe and select held low
// - first access long pulse, then short
// - page reads ignore setups and cycle
// - page timings used unchecked as programmed
// - byte access type kept in page mode
// - same select and page: short hit
// - other page or select: long access
// - foreign access between breaks the page
// - wait sampled only in strobe pulse
`include "smwsp_defs.svh"
`default_nettype none
module smwsp_seq #(
  parameter int CS_COUNT = 8,
  parameter int ADDR_W = 26
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic slow_clock_in,
  input wire logic ext_wait_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [`SMWSP_CS_W-1:0] req_cs,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire smwsp_pkg::smwsp_cfg_t req_cfg,
  input wire logic other_access,
  output logic req_ready,
  output logic xfer_done,
  output logic [CS_COUNT-1:0] chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [ADDR_W-1:0] mem_addr,
  output logic byte_select_mode,
  output logic page_hit,
  output logic slow_mode_active,
  output logic reload_wait
);

  // refuse sizes the decode cannot serve
  if (CS_COUNT < 1 || CS_COUNT > (1 << `SMWSP_CS_W))
  begin : g_bad_cs
    $error("CS_COUNT out of range");
  end
  if (ADDR_W < 6)
  begin : g_bad_addr
    $error("ADDR_W too small for 32-byte pages");
  end

  localparam int CW = `SMWSP_CNT_W;

  // page number: address with in-page bits cleared
  function automatic logic [ADDR_W-1:0] page_base(
    input logic [ADDR_W-1:0] a,
    input logic [1:0] ps
  );
    logic [ADDR_W-1:0] m;
    m = '1;
    case (ps)
      `SMWSP_PS_4: m[1:0] = '0;
      `SMWSP_PS_8: m[2:0] = '0;
      `SMWSP_PS_16: m[3:0] = '0;
      default: m[4:0] = '0;
    endcase
    return a & m;
  endfunction

  // true while c lies in [s, s+l)
  function automatic logic in_win(
    input logic [CW-1:0] c,
    input logic [CW-1:0] s,
    input logic [CW-1:0] l
  );
    logic [CW:0] e;
    e = {1'b0, s} + {1'b0, l};
    return ({1'b0, c} >= {1'b0, s}) && ({1'b0, c} < e);
  endfunction

  // wait pin synchroniser: first flop feeds only the second
  logic wait_s1_reg;
  logic wait_s2_reg;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wait_s1_reg <= 1'b1;
      wait_s2_reg <= 1'b1;
    end
    else if (clk_en)
    begin
      wait_s1_reg <= ext_wait_n;
      wait_s2_reg <= wait_s1_reg;
    end
  end

  smwsp_pkg::smwsp_state_t state_reg, state_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  smwsp_pkg::smwsp_tim_t tim_reg, tim_next;
  logic wr_reg, wr_next;
  logic [`SMWSP_CS_W-1:0] cs_reg, cs_next;
  logic [1:0] wmode_reg, wmode_next;
  logic page_run_reg, page_run_next;
  logic open_reg, open_next;
  logic pvalid_reg, pvalid_next;
  logic [`SMWSP_CS_W-1:0] pcs_reg, pcs_next;
  logic [ADDR_W-1:0] pbase_reg, pbase_next;
  logic slow_reg, slow_next;
  logic ready_next, done_next, hit_next, bat_next, reload_next;
  logic rd_n_next, wr_n_next;
  logic [ADDR_W-1:0] addr_next;
  logic [CS_COUNT-1:0] cs_n_next;

  logic take, hit, page_req, stall, waiting, rd_low, cs_low;
  logic [CW:0] pulse_end;
  logic [CW-1:0] short_p;
  smwsp_pkg::smwsp_tim_t slow_rd, slow_wr, page_t;

  // fixed slow-clock waveforms
  always_comb
  begin
    slow_rd = '{`SMWSP_SLOW_RD_SETUP, `SMWSP_SLOW_RD_PULSE,
      `SMWSP_SLOW_CS_RD_SETUP, `SMWSP_SLOW_CS_RD_PULSE,
      `SMWSP_SLOW_RD_CYCLE};
    slow_wr = '{`SMWSP_SLOW_WR_SETUP, `SMWSP_SLOW_WR_PULSE,
      `SMWSP_SLOW_CS_WR_SETUP, `SMWSP_SLOW_CS_WR_PULSE,
      `SMWSP_SLOW_WR_CYCLE};
  end

  // request decode and page hit test
  always_comb
  begin
    take = req_ready && req_valid;
    hit = pvalid_reg && (pcs_reg == req_cs) &&
      (pbase_reg == page_base(req_addr, req_cfg.page_size_sel));
    // page bursts only for normal-speed reads with page mode on
    page_req = !req_write && req_cfg.page_mode_enable && !slow_reg;
    // long pulse on a new page, short one on a hit
    short_p = hit ? req_cfg.rd.pulse : req_cfg.rd.cs_pulse;
    // setups and cycle dropped; no check that tpa >= tsa
    page_t = '{'0, short_p, '0, short_p, short_p};
  end

  // wait decision on the synchronised level, pulse phase only
  always_comb
  begin
    pulse_end = {1'b0, tim_reg.setup} + {1'b0, tim_reg.pulse};
    waiting = !wait_s2_reg && !page_run_reg && !slow_reg;
    stall = 1'b0;
    if (state_reg == smwsp_pkg::SMWSP_RUN && waiting)
    begin
      if (wmode_reg == `SMWSP_WAIT_FROZEN)
        stall = in_win(cnt_reg, tim_reg.setup, tim_reg.pulse);
      else if (wmode_reg == `SMWSP_WAIT_READY)
        stall = ({1'b0, cnt_reg} + 11'h001) == pulse_end;
    end
  end

  // sequencer next state
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    tim_next = tim_reg;
    wr_next = wr_reg;
    cs_next = cs_reg;
    wmode_next = wmode_reg;
    page_run_next = page_run_reg;
    open_next = open_reg;
    pvalid_next = pvalid_reg;
    pcs_next = pcs_reg;
    pbase_next = pbase_reg;
    slow_next = slow_reg;
    addr_next = mem_addr;
    hit_next = page_hit;
    bat_next = byte_select_mode;
    done_next = 1'b0;
    case (state_reg)
      smwsp_pkg::SMWSP_IDLE:
      begin
        if (take)
        begin
          wr_next = req_write;
          cs_next = req_cs;
          wmode_next = req_cfg.external_wait_mode;
          bat_next = req_cfg.byte_access_type;
          addr_next = req_addr;
          // narrow lanes are not part of the word address
          if (req_cfg.data_bus_width == `SMWSP_DBW_16)
            addr_next[0] = 1'b0;
          else if (req_cfg.data_bus_width == `SMWSP_DBW_32)
            addr_next[1:0] = 2'h0;
          page_run_next = page_req;
          hit_next = page_req && hit;
          cnt_next = '0;
          if (slow_reg)
            tim_next = req_write ? slow_wr : slow_rd;
          else if (page_req)
            tim_next = page_t;
          else
            tim_next = req_write ? req_cfg.wr : req_cfg.rd;
          // record the page this read opens
          pvalid_next = page_req;
          pcs_next = req_cs;
          pbase_next = page_base(req_addr, req_cfg.page_size_sel);
          // a held page closes unless this read hits it
          if (open_reg && !(page_req && hit))
          begin
            open_next = 1'b0;
            state_next = smwsp_pkg::SMWSP_BREAK;
          end
          else
            state_next = smwsp_pkg::SMWSP_RUN;
        end
        else if (other_access)
        begin
          // foreign access lifts the select and forgets the page
          open_next = 1'b0;
          pvalid_next = 1'b0;
        end
        else if (slow_clock_in != slow_reg)
        begin
          // switch only between transfers, so a running one kept its set
          slow_next = slow_clock_in;
          open_next = 1'b0;
          pvalid_next = 1'b0;
          state_next = smwsp_pkg::SMWSP_RELOAD;
        end
      end
      smwsp_pkg::SMWSP_RELOAD:
        state_next = smwsp_pkg::SMWSP_IDLE;
      smwsp_pkg::SMWSP_BREAK:
        state_next = smwsp_pkg::SMWSP_RUN;
      smwsp_pkg::SMWSP_RUN:
      begin
        if (!stall)
        begin
          if ({1'b0, cnt_reg} + 11'h001 >= {1'b0, tim_reg.cycle})
          begin
            done_next = 1'b1;
            open_next = page_run_reg;
            state_next = smwsp_pkg::SMWSP_IDLE;
          end
          else
            cnt_next = cnt_reg + 10'h001;
        end
      end
      default:
        state_next = smwsp_pkg::SMWSP_IDLE;
    endcase
  end

  // pin levels for the cycle being entered
  always_comb
  begin
    rd_low = 1'b0;
    cs_low = open_next;
    if (state_next == smwsp_pkg::SMWSP_RUN)
    begin
      rd_low = in_win(cnt_next, tim_next.setup, tim_next.pulse);
      cs_low = cs_low ||
        in_win(cnt_next, tim_next.cs_setup, tim_next.cs_pulse);
    end
    rd_n_next = !(rd_low && !wr_next) && !(open_next && !wr_next);
    wr_n_next = !(rd_low && wr_next);
    ready_next = (state_next == smwsp_pkg::SMWSP_IDLE) &&
      (slow_clock_in == slow_next);
    reload_next = state_next == smwsp_pkg::SMWSP_RELOAD;
    cs_n_next = '1;
    for (int i = 0; i < CS_COUNT; i++)
      if (cs_low && cs_next == i[`SMWSP_CS_W-1:0])
        cs_n_next[i] = 1'b0;
  end

  // sequencer registers; page record empty after reset
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg <= smwsp_pkg::SMWSP_IDLE;
      cnt_reg <= '0;
      tim_reg <= '0;
      wr_reg <= 1'b0;
      cs_reg <= '0;
      wmode_reg <= 2'h0;
      page_run_reg <= 1'b0;
      open_reg <= 1'b0;
      pvalid_reg <= 1'b0;
      pcs_reg <= '0;
      pbase_reg <= '0;
      slow_reg <= 1'b0;
      req_ready <= 1'b0;
      xfer_done <= 1'b0;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      mem_addr <= '0;
      byte_select_mode <= 1'b0;
      page_hit <= 1'b0;
      reload_wait <= 1'b0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      tim_reg <= tim_next;
      wr_reg <= wr_next;
      cs_reg <= cs_next;
      wmode_reg <= wmode_next;
      page_run_reg <= page_run_next;
      open_reg <= open_next;
      pvalid_reg <= pvalid_next;
      pcs_reg <= pcs_next;
      pbase_reg <= pbase_next;
      slow_reg <= slow_next;
      req_ready <= ready_next;
      xfer_done <= done_next;
      read_strobe_n <= rd_n_next;
      write_strobe_n <= wr_n_next;
      mem_addr <= addr_next;
      byte_select_mode <= bat_next;
      page_hit <= hit_next;
      reload_wait <= reload_next;
    end
  end

  // slow mode flag straight from its flop
  always_comb
  begin
    slow_mode_active = slow_reg;
  end

  // one flop per chip select pin
  for (genvar g = 0; g < CS_COUNT; g++)
  begin : g_cs
    always_ff @(posedge ref_clk)
    begin
      if (rst)
        chip_select_n[g] <= 1'b1;
      else if (clk_en)
        chip_select_n[g] <= cs_n_next[g];
    end
  end

endmodule
`default_nettype wire

// file: sim/smwsp_sva.sv
// port assertions for the access sequencer
`default_nettype none
module smwsp_chk #(
  parameter int CS_COUNT = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_ready,
  input wire logic xfer_done,
  input wire logic other_access,
  input wire logic [CS_COUNT-1:0] chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic page_hit,
  input wire logic slow_mode_active,
  input wire logic reload_wait
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic take;
  logic cs_on;
  // a taken request, and any select driven low
  assign take = req_valid && req_ready && clk_en;
  assign cs_on = !(&chip_select_n);
  sequence s_slow_rd;
    cs_on && read_strobe_n ##1 cs_on && !read_strobe_n
    ##1 !cs_on && xfer_done;
  endsequence
  sequence s_slow_wr;
    cs_on && write_strobe_n ##1 cs_on && !write_strobe_n
    ##1 cs_on && write_strobe_n ##1 !cs_on && xfer_done;
  endsequence
  AST_SLOW_RD: assert property (
    take && slow_mode_active && !req_write |=> s_slow_rd)
    else $error("slow read waveform wrong");
  AST_SLOW_WR: assert property (
    take && slow_mode_active && req_write |=> s_slow_wr)
    else $error("slow write waveform wrong");
  AST_RELOAD_CHG: assert property (
    $changed(slow_mode_active) |-> reload_wait)
    else $error("mode changed without reload wait");
  AST_RELOAD_ONE: assert property (reload_wait |=> !reload_wait)
    else $error("reload wait longer than one cycle");
  AST_RELOAD_IDLE: assert property (
    reload_wait |-> !req_ready && !cs_on)
    else $error("access during reload wait");
  AST_PAGE_TIED: assert property (
    page_hit |-> read_strobe_n == !cs_on)
    else $error("page strobe and select differ");
  AST_PAGE_CLOSE: assert property (
    other_access && req_ready && !take |=> !cs_on && read_strobe_n)
    else $error("page left open after other access");
  AST_DONE_PULSE: assert property (xfer_done |=> !xfer_done)
    else $error("done longer than one cycle");
endmodule
bind smwsp_seq smwsp_chk #(.CS_COUNT(CS_COUNT)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .req_valid(req_valid),
  .req_write(req_write), .req_ready(req_ready), .xfer_done(xfer_done),
  .other_access(other_access), .chip_select_n(chip_select_n),
  .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
  .page_hit(page_hit), .slow_mode_active(slow_mode_active),
  .reload_wait(reload_wait)
);
`default_nettype wire

// file: sim/smwsp_mem.sv
// far-side memory model: answers a strobe with an optional wait pulse
`default_nettype none
module smwsp_mem (
  input wire logic ref_clk,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [3:0] wait_len,
  output logic ext_wait_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic strobe_q = 1'b1;
  logic [3:0] left = 4'h0;
  // one cycle of latency, then low for wait_len cycles; pulled up otherwise
  always @(posedge ref_clk)
  begin
    strobe_q <= read_strobe_n & write_strobe_n;
    if (strobe_q && !(read_strobe_n & write_strobe_n))
      left <= wait_len;
    else if (left != 4'h0)
      left <= left - 4'h1;
  end
  assign ext_wait_n = (left == 4'h0);
endmodule
`default_nettype wire

// file: sim/static_mem_wait_slowclk_page_bench.sv
// self-checking bench for the access sequencer
`include "smwsp_defs.svh"
`default_nettype none
module static_mem_wait_slowclk_page_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic slow_clock_in = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [2:0] req_cs = 3'h0;
  logic [25:0] req_addr = 26'h0;
  smwsp_pkg::smwsp_cfg_t req_cfg = '0;
  logic other_access = 1'b0;
  logic drop_slow = 1'b0;
  logic clk_en = 1'b1;
  int freeze = 0;
  logic [3:0] wait_len = 4'h0;
  logic ext_wait_n, req_ready, xfer_done, read_strobe_n, write_strobe_n;
  logic byte_select_mode, page_hit, slow_mode_active, reload_wait;
  logic [7:0] chip_select_n;
  logic [25:0] mem_addr, sz;
  logic [31:0] seed = 32'hD8ED;
  logic [31:0] r;
  int num_errors = 0;
  int cmp_count = 0;
  smwsp_seq u_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .slow_clock_in(slow_clock_in), .ext_wait_n(ext_wait_n),
    .req_valid(req_valid), .req_write(req_write), .req_cs(req_cs),
    .req_addr(req_addr), .req_cfg(req_cfg), .other_access(other_access),
    .req_ready(req_ready), .xfer_done(xfer_done),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .mem_addr(mem_addr),
    .byte_select_mode(byte_select_mode), .page_hit(page_hit),
    .slow_mode_active(slow_mode_active), .reload_wait(reload_wait));
  smwsp_mem u_mem (.ref_clk(ref_clk), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .wait_len(wait_len),
    .ext_wait_n(ext_wait_n));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // sane random waveform: cycle never shorter than setup plus pulse
  function automatic smwsp_pkg::smwsp_tim_t tim(input logic [31:0] v);
    tim.setup = {8'h00, v[1:0]};
    tim.pulse = {8'h00, v[3:2]} + 10'h001;
    tim.cs_setup = {8'h00, v[5:4]};
    tim.cs_pulse = {8'h00, v[7:6]} + 10'h001;
    tim.cycle = tim.setup + tim.pulse + {8'h00, v[9:8]};
  endfunction
  function automatic logic [25:0] exp_addr(input logic [25:0] a);
    if (req_cfg.data_bus_width == `SMWSP_DBW_16)
      return {a[25:1], 1'h0};
    return (req_cfg.data_bus_width == `SMWSP_DBW_32) ? {a[25:2], 2'h0} : a;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one request; n counts edges from take to done
  task automatic xfer(input logic w, input logic [2:0] cs,
    input logic [25:0] a, input logic hit, input int exp_n);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_write = w;
    req_cs = cs;
    req_addr = a;
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(negedge ref_clk);
      n++;
    end
    check(req_ready, 1'b1);
    @(negedge ref_clk);
    req_valid = 1'b0;
    if (drop_slow)
      slow_clock_in = 1'b0;
    check(mem_addr, exp_addr(a));
    check(byte_select_mode, req_cfg.byte_access_type);
    check(page_hit, hit);
    // frozen cycles must not advance the access
    if (freeze > 0)
    begin
      clk_en = 1'b0;
      repeat (freeze) @(negedge ref_clk);
      clk_en = 1'b1;
    end
    n = 1;
    while (xfer_done !== 1'b1 && n < 300)
    begin
      @(negedge ref_clk);
      n++;
    end
    check(n, exp_n);
  endtask
  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end
  initial
  begin
    #60000;
    num_errors++;
    summarize();
  end
  initial
  begin
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    for (int i = 0; i < 20; i++)
    begin
      r = rnd();
      req_cfg.rd = tim(r);
      req_cfg.wr = tim(r >> 10);
      req_cfg.data_bus_width = (r[21:20] == 2'h3) ? 2'h0 : r[21:20];
      req_cfg.byte_access_type = r[22];
      xfer(r[23], r[26:24], r[31:6], 1'b0, 1 + int'(r[23] ?
        req_cfg.wr.cycle : req_cfg.rd.cycle));
    end
    $display("random transfers done");
    req_cfg.rd = '{10'h001, 10'h005, 10'h000, 10'h007, 10'h007};
    req_cfg.external_wait_mode = `SMWSP_WAIT_FROZEN;
    wait_len = 4'h2;
    xfer(1'b0, 3'h1, 26'h40, 1'b0, 10);
    req_cfg.external_wait_mode = `SMWSP_WAIT_READY;
    wait_len = 4'h4;
    xfer(1'b0, 3'h1, 26'h40, 1'b0, 11);
    req_cfg.rd = '{10'h001, 10'h002, 10'h000, 10'h004, 10'h004};
    req_cfg.external_wait_mode = `SMWSP_WAIT_FROZEN;
    wait_len = 4'h2;
    xfer(1'b0, 3'h1, 26'h40, 1'b0, 5);
    $display("external wait done");
    slow_clock_in = 1'b1;
    // ready is registered: let the reload cycle start first
    @(negedge ref_clk);
    check(reload_wait, 1'b1);
    check(slow_mode_active, 1'b1);
    xfer(1'b0, 3'h5, 26'h123, 1'b0, 3);
    xfer(1'b1, 3'h6, 26'h124, 1'b0, 4);
    drop_slow = 1'b1;
    xfer(1'b0, 3'h5, 26'h125, 1'b0, 3);
    drop_slow = 1'b0;
    wait_len = 4'h0;
    req_cfg.external_wait_mode = 2'h0;
    xfer(1'b0, 3'h5, 26'h125, 1'b0, 5);
    check(slow_mode_active, 1'b0);
    $display("slow clock done");
    // page reads never use the wait input
    req_cfg.external_wait_mode = 2'h0;
    req_cfg.rd = '{10'h002, 10'h002, 10'h001, 10'h004, 10'h009};
    req_cfg.page_mode_enable = 1'b1;
    req_cfg.data_bus_width = `SMWSP_DBW_16;
    req_cfg.byte_access_type = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      req_cfg.page_size_sel = k[1:0];
      sz = 26'h4 << k;
      xfer(1'b0, k[2:0], 26'h100, 1'b0, 5 + (k > 0));
      check(chip_select_n, {24'h0, ~(8'h01 << k)});
      check(read_strobe_n, 1'b0);
      xfer(1'b0, k[2:0], 26'h0FF + sz, 1'b1, 3);
      xfer(1'b0, k[2:0], 26'h100 + sz, 1'b0, 6);
    end
    req_cfg.rd = '{10'h002, 10'h003, 10'h001, 10'h001, 10'h009};
    xfer(1'b0, 3'h3, 26'h13F, 1'b1, 4);
    other_access = 1'b1;
    @(negedge ref_clk);
    other_access = 1'b0;
    xfer(1'b0, 3'h3, 26'h13F, 1'b0, 2);
    req_cfg.page_mode_enable = 1'b0;
    xfer(1'b0, 3'h3, 26'h13F, 1'b0, 11);
    freeze = 3;
    xfer(1'b0, 3'h3, 26'h13F, 1'b0, 10);
    $display("page mode done");
    summarize();
  end
endmodule
`default_nettype wire
